//--- logic/rrcx_pkg.sv
/*
 Package for the rotate-right-through-carry execution datapath: opcode
 fields, bank layout constants, flag positions and the four-phase cycle.
 Assumes one core clock and one core reset shared by all users.
*/
package rrcx_pkg;

	// ------------------------------------------------------------
	// Instruction word layout
	// ------------------------------------------------------------
	localparam int          RRCX_OPC_MSB     = 15;
	localparam int          RRCX_OPC_LSB     = 10;
	localparam logic [5:0]  RRCX_OPC_ROTR    = 6'h0c;
	localparam int          RRCX_DEST_BIT    = 9;
	localparam int          RRCX_BANK_BIT    = 8;
	localparam int          RRCX_ADDR_MSB    = 7;

	// ------------------------------------------------------------
	// Addressing
	// ------------------------------------------------------------
	localparam logic [7:0]  RRCX_IDX_LIMIT   = 8'h5f;
	localparam logic [7:0]  RRCX_ACC_HI_BASE = 8'h60;
	localparam logic [3:0]  RRCX_BANK_LOW    = 4'h0;
	localparam logic [3:0]  RRCX_BANK_HIGH   = 4'hf;

	// ------------------------------------------------------------
	// Flags and reset values
	// ------------------------------------------------------------
	localparam int          RRCX_FLAG_C      = 0;
	localparam int          RRCX_FLAG_Z      = 2;
	localparam int          RRCX_FLAG_N      = 4;
	localparam logic [7:0]  RRCX_BYTE_RST    = 8'h00;

	// ------------------------------------------------------------
	// Four-phase cycle
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RRCX_Q1 = 2'b00,
		RRCX_Q2 = 2'b01,
		RRCX_Q3 = 2'b11,
		RRCX_Q4 = 2'b10
	} rrcx_phase_t;

endpackage : rrcx_pkg

//--- logic/rrcx_alu.sv
/*
 Combinational rotate-right-through-carry unit with N and Z flags.
 Assumes a stable operand and carry across the process phase.
*/
`timescale 1ns/10ps
`default_nettype none

module rrcx_alu (
	// Operand in
	input  wire logic [7:0] opnd,
	input  wire logic       carry_in,
	// Result out
	output logic      [7:0] result,
	output logic            carry_out,
	output logic            neg,
	output logic            zero
);

	// ------------------------------------------------------------
	// Rotate one place toward bit 0 through carry
	// ------------------------------------------------------------
	always_comb begin
		result    = {carry_in, opnd[7:1]};
		carry_out = opnd[0];
		neg       = result[7];
		zero      = (result == 8'h00);
	end

endmodule // rrcx_alu

`default_nettype wire

//--- logic/rrcx_exec.sv
/*
 Execution block for rotate right through carry: decode in Q1, operand
 read and rotate in Q2, write enables set in Q3, destination write in Q4.
 Assumes the register file answers rd_data combinationally from rd_addr
 in the same core clock, and that instr is held for a whole cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module rrcx_exec
	import rrcx_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// Instruction and core state
	input  wire logic [15:0] instr,
	input  wire logic        ext_set_en,
	input  wire logic [3:0]  bank_select_register,
	input  wire logic [11:0] index_base,
	input  wire logic        carry_flag,
	// Register file read
	output logic      [11:0] rd_addr,
	input  wire logic [7:0]  rd_data,
	// Destination writes
	output logic             acc_we,
	output logic      [7:0]  acc_wdata,
	output logic             reg_we,
	output logic      [11:0] reg_waddr,
	output logic      [7:0]  reg_wdata,
	output logic             flag_we,
	output logic      [7:0]  flag_wmask,
	output logic      [7:0]  flag_wdata,
	// Status
	output logic      [1:0]  phase,
	output logic             busy
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		rrcx_phase_t ph;
		logic        hit;
		logic        dest;
		logic [11:0] addr;
		logic [7:0]  res;
		logic        c;
		logic        n;
		logic        z;
		logic        acc_we;
		logic        reg_we;
		logic        flag_we;
		logic [7:0]  wdata;
		logic [11:0] waddr;
	} rrcx_state_t;

	rrcx_state_t st_ff;
	rrcx_state_t nxt_st;

	logic [7:0] alu_res;
	logic       alu_c;
	logic       alu_n;
	logic       alu_z;

	// Opcode field match, shared by decode and the checks
	function automatic logic rrcx_is_rot(input logic [15:0] w);
		return w[RRCX_OPC_MSB:RRCX_OPC_LSB] == RRCX_OPC_ROTR;
	endfunction

	// Effective address from the bank, index and direct modes
	function automatic logic [11:0] rrcx_ea(input logic a, input logic x,
		input logic [7:0] f, input logic [3:0] bank, input logic [11:0] base);
		logic [11:0] ea;
		ea = {bank, f};
		if (!a) begin
			if (x && f <= RRCX_IDX_LIMIT) begin
				ea = base + {4'h0, f};
			end else if (f < RRCX_ACC_HI_BASE) begin
				ea = {RRCX_BANK_LOW, f};
			end else begin
				ea = {RRCX_BANK_HIGH, f};
			end
		end
		return ea;
	endfunction

	rrcx_alu u_alu (
		.opnd      (rd_data),
		.carry_in  (carry_flag),
		.result    (alu_res),
		.carry_out (alu_c),
		.neg       (alu_n),
		.zero      (alu_z)
	);

	// ------------------------------------------------------------
	// Phase sequencer and datapath
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.acc_we  = 1'b0;
		nxt_st.reg_we  = 1'b0;
		nxt_st.flag_we = 1'b0;
		case (st_ff.ph)
			RRCX_Q1: begin
				nxt_st.ph   = RRCX_Q2;
				nxt_st.hit  = rrcx_is_rot(instr);
				nxt_st.dest = instr[RRCX_DEST_BIT];
				nxt_st.addr = rrcx_ea(instr[RRCX_BANK_BIT], ext_set_en,
					instr[RRCX_ADDR_MSB:0], bank_select_register, index_base);
			end
			RRCX_Q2: begin
				nxt_st.ph = RRCX_Q3;
				nxt_st.res = alu_res;
				nxt_st.c   = alu_c;
				nxt_st.n   = alu_n;
				nxt_st.z   = alu_z;
			end
			RRCX_Q3: begin
				// Writes land at the Q4 edge, one cycle wide while clk_en stays high
				nxt_st.ph      = RRCX_Q4;
				nxt_st.acc_we  = st_ff.hit && !st_ff.dest;
				nxt_st.reg_we  = st_ff.hit && st_ff.dest;
				nxt_st.flag_we = st_ff.hit;
				nxt_st.wdata   = st_ff.res;
				nxt_st.waddr   = st_ff.addr;
			end
			RRCX_Q4: begin
				nxt_st.ph  = RRCX_Q1;
				nxt_st.hit = 1'b0;
			end
			default: begin
				nxt_st.ph = RRCX_Q1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rd_addr    = st_ff.addr;
	assign acc_we     = st_ff.acc_we;
	assign acc_wdata  = st_ff.wdata;
	assign reg_we     = st_ff.reg_we;
	assign reg_waddr  = st_ff.waddr;
	assign reg_wdata  = st_ff.wdata;
	assign flag_we    = st_ff.flag_we;
	// Only C, Z and N are touched; other status bits keep their value
	assign flag_wmask = (8'h01 << RRCX_FLAG_C) | (8'h01 << RRCX_FLAG_Z) |
		(8'h01 << RRCX_FLAG_N);
	assign flag_wdata = ({7'h00, st_ff.c} << RRCX_FLAG_C) |
		({7'h00, st_ff.z} << RRCX_FLAG_Z) | ({7'h00, st_ff.n} << RRCX_FLAG_N);
	assign phase      = st_ff.ph;
	assign busy       = st_ff.hit;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_rotate_result: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q2) |=> (st_ff.res == {$past(carry_flag), $past(rd_data[7:1])})
		&& st_ff.c == $past(rd_data[0]))
		else $error("rotate result or carry wrong");
	a_flag_nz: assert property (@(posedge clk_sys) disable iff (rst)
		flag_we |-> (flag_wdata[RRCX_FLAG_Z] == (acc_wdata == 8'h00))
		&& flag_wdata[RRCX_FLAG_N] == acc_wdata[7])
		else $error("N or Z flag wrong");
	a_dest_acc: assert property (@(posedge clk_sys) disable iff (rst)
		acc_we |-> !reg_we && !st_ff.dest && flag_we)
		else $error("accumulator write with wrong dest");
	a_dest_reg: assert property (@(posedge clk_sys) disable iff (rst)
		reg_we |-> !acc_we && st_ff.dest && reg_waddr == st_ff.addr)
		else $error("register write with wrong dest");
	a_bank_select: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q1 && instr[RRCX_BANK_BIT])
		|=> rd_addr == {$past(bank_select_register), $past(instr[7:0])})
		else $error("bank select address wrong");
	a_bank_low: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q1 && !instr[RRCX_BANK_BIT] && !ext_set_en
		&& instr[7:0] < RRCX_ACC_HI_BASE) |=> rd_addr == {4'h0, $past(instr[7:0])})
		else $error("direct low bank address wrong");
	a_index_mode: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q1 && !instr[RRCX_BANK_BIT] && ext_set_en
		&& instr[7:0] <= RRCX_IDX_LIMIT)
		|=> rd_addr == $past(index_base) + {4'h0, $past(instr[7:0])})
		else $error("indexed literal offset address wrong");
	a_decode_miss: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q1 && !rrcx_is_rot(instr))
		|=> !busy ##2 !acc_we && !reg_we && !flag_we)
		else $error("write for a foreign opcode");
	// A pulse may stay past Q4 only while the enable holds it frozen
	a_write_timing: assert property (@(posedge clk_sys) disable iff (rst)
		flag_we |-> st_ff.ph == RRCX_Q4 && ($past(st_ff.ph) == RRCX_Q3 || !$past(clk_en)))
		else $error("write outside Q4");
	a_bank_high: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q1 && !instr[RRCX_BANK_BIT]
		&& instr[7:0] >= RRCX_ACC_HI_BASE)
		|=> rd_addr == {RRCX_BANK_HIGH, $past(instr[7:0])})
		else $error("direct high bank address wrong");
	// A low enable must leave every state bit alone, pulses included
	a_enable_freeze: assert property (@(posedge clk_sys) disable iff (rst)
		!clk_en |=> $stable(st_ff))
		else $error("state moved while enable was low");
	a_busy_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(clk_en && st_ff.ph == RRCX_Q4) |=> !busy && !flag_we && !acc_we && !reg_we)
		else $error("write pulse or busy outlived Q4");

endmodule // rrcx_exec

`default_nettype wire

//--- testbench/rrcx_exec_bench.sv
/*
 Self-checking bench for the rotate-right-through-carry execution block.
 Assumes the design package is compiled first; the bench stands in for
 the register file and core state, answering rd_data itself.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module rrcx_exec_bench;
	import rrcx_pkg::*;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic [15:0] instr = 16'h0000;
	logic        ext_set_en = 1'b0;
	logic [3:0]  bank_select_register = 4'h0;
	logic [11:0] index_base = 12'h100;
	logic        carry_flag = 1'b0;
	logic [7:0]  rd_data = 8'h00;
	logic [11:0] rd_addr, reg_waddr;
	logic [7:0]  acc_wdata, reg_wdata, flag_wmask, flag_wdata;
	logic        acc_we, reg_we, flag_we, busy;
	logic [1:0]  phase;
	int          fail_count = 0;
	int          n_checks = 0;

	rrcx_exec dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .instr(instr),
		.ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
		.index_base(index_base), .carry_flag(carry_flag), .rd_addr(rd_addr),
		.rd_data(rd_data), .acc_we(acc_we), .acc_wdata(acc_wdata), .reg_we(reg_we),
		.reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .flag_we(flag_we),
		.flag_wmask(flag_wmask), .flag_wdata(flag_wdata), .phase(phase), .busy(busy));

	// 20 MHz core clock
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Verdict; the single exit of the run
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bounded wait at falling edges for a phase; expiry ends the run
	task automatic wait_phase(input logic [1:0] ph);
		for (int i = 0; i < 8 && phase !== ph; i++)
			@(negedge clk_sys);
		if (phase !== ph) begin
			fail_count++;
			test_done();
		end
	endtask

	// One instruction, driven in Q1 and judged in Q4 and the following Q1
	task automatic run_op(input logic [15:0] ins, input logic [7:0] data,
		input logic c, input logic ext, input logic [3:0] bank, input logic [11:0] addr);
		logic       hit;
		logic [7:0] res;
		hit = (ins[15:10] == 6'b001100);
		res = {c, data[7:1]};
		wait_phase(RRCX_Q1);
		instr = ins;
		rd_data = data;
		carry_flag = c;
		ext_set_en = ext;
		bank_select_register = bank;
		@(negedge clk_sys);
		wait_phase(RRCX_Q4);
		`CHK(flag_we, hit)
		`CHK(acc_we, hit & ~ins[9])
		`CHK(reg_we, hit & ins[9])
		`CHK(busy, hit)
		if (hit) begin
			`CHK(rd_addr, addr)
			`CHK(acc_wdata, res)
			`CHK(reg_wdata, res)
			`CHK(flag_wmask, 8'h15)
			`CHK(flag_wdata, {3'b000, res[7], 1'b0, res == 8'h00, 1'b0, data[0]})
			if (ins[9])
				`CHK(reg_waddr, addr)
		end
		@(negedge clk_sys);
		// Pulses last one cycle only
		`CHK({acc_we, reg_we, flag_we, busy}, 4'h0)
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Carry in and out, zero and negative results, both destinations
	task automatic t_rotate();
		run_op(16'h3334, 8'ha5, 1'b1, 1'b0, 4'h5, 12'h534);
		run_op(16'h3134, 8'h01, 1'b0, 1'b0, 4'h5, 12'h534);
		run_op(16'h33ff, 8'h80, 1'b0, 1'b0, 4'ha, 12'haff);
		run_op(16'h3100, 8'h7e, 1'b1, 1'b0, 4'h0, 12'h000);
		$display("rotate test done");
	endtask

	// Bank sources, with the indexed boundary at 5f and 60
	task automatic t_bank();
		run_op(16'h3220, 8'h12, 1'b0, 1'b0, 4'h7, 12'h020);
		run_op(16'h3280, 8'h34, 1'b1, 1'b0, 4'h7, 12'hf80);
		run_op(16'h325f, 8'h56, 1'b0, 1'b1, 4'h7, 12'h15f);
		run_op(16'h3260, 8'h78, 1'b1, 1'b1, 4'h7, 12'hf60);
		run_op(16'h3000, 8'h9a, 1'b0, 1'b1, 4'h7, 12'h100);
		run_op(16'h3360, 8'hbc, 1'b1, 1'b1, 4'h7, 12'h760);
		$display("bank test done");
	endtask

	// Neighbouring opcodes must produce no writes
	task automatic t_refuse();
		run_op(16'h3634, 8'h55, 1'b1, 1'b0, 4'h1, 12'h000);
		run_op(16'h2e34, 8'h55, 1'b1, 1'b0, 4'h1, 12'h000);
		run_op(16'h7134, 8'h55, 1'b0, 1'b0, 4'h1, 12'h000);
		$display("refuse test done");
	endtask

	// Enable low freezes the sequence in Q2 and holds the Q4 pulses
	task automatic t_hold();
		wait_phase(RRCX_Q1);
		instr = 16'h3134;
		rd_data = 8'h03;
		carry_flag = 1'b1;
		ext_set_en = 1'b0;
		bank_select_register = 4'h2;
		@(negedge clk_sys);
		clk_en = 1'b0;
		repeat (2) @(negedge clk_sys);
		`CHK(phase, RRCX_Q2)
		`CHK(busy, 1'b1)
		// Operand changes while frozen; only the enabled edge may sample it
		rd_data = 8'h81;
		carry_flag = 1'b0;
		clk_en = 1'b1;
		wait_phase(RRCX_Q4);
		`CHK(acc_we, 1'b1)
		`CHK(acc_wdata, 8'h40)
		`CHK(flag_wdata, 8'h01)
		`CHK(rd_addr, 12'h234)
		clk_en = 1'b0;
		@(negedge clk_sys);
		`CHK({phase, acc_we, flag_we}, 4'b1011)
		clk_en = 1'b1;
		@(negedge clk_sys);
		`CHK({acc_we, reg_we, flag_we, busy}, 4'h0)
		$display("hold test done");
	endtask

	// Reset in mid-instruction drops the pulses; the next op runs clean
	task automatic t_reset();
		wait_phase(RRCX_Q1);
		instr = 16'h3334;
		rd_data = 8'h5a;
		carry_flag = 1'b1;
		ext_set_en = 1'b0;
		bank_select_register = 4'h3;
		@(negedge clk_sys);
		wait_phase(RRCX_Q4);
		`CHK(reg_we, 1'b1)
		rst = 1'b1;
		@(negedge clk_sys);
		`CHK({phase, busy, acc_we, reg_we, flag_we}, 6'h00)
		`CHK({rd_addr, reg_wdata, flag_wdata}, 28'h0)
		rst = 1'b0;
		run_op(16'h3334, 8'h5a, 1'b1, 1'b0, 4'h3, 12'h334);
		$display("reset test done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		t_rotate();
		t_bank();
		t_refuse();
		t_hold();
		t_reset();
		test_done();
	end

endmodule // rrcx_exec_bench

`default_nettype wire
